/* inc/fsts_map.svh */
// timing constants for the floppy sector timing separator
`ifndef FSTS_MAP_SVH
`define FSTS_MAP_SVH

// reference clock and local logic clock
`define FSTS_REF_NS 25
`define FSTS_LOCAL_CLOCK_N_NS 500
`define FSTS_LOCAL_CLOCK_N_CYC (`FSTS_LOCAL_CLOCK_N_NS / `FSTS_REF_NS)
`define FSTS_TICK_PER_US (1000 / `FSTS_LOCAL_CLOCK_N_NS)

// divider chain
`define FSTS_TAP8_US 8
`define FSTS_TAP8_DIV (`FSTS_TAP8_US * `FSTS_TICK_PER_US)
`define FSTS_CHAIN_DIV 16
`define FSTS_TAP2_MS 2
`define FSTS_SLOW_MS 500
`define FSTS_SLOW_DIV (`FSTS_SLOW_MS / `FSTS_TAP2_MS)
`define FSTS_AUTO_OFF_MS 8300
`define FSTS_AUTO_OFF_DIV (`FSTS_AUTO_OFF_MS / `FSTS_SLOW_MS)

// per-sector timing in microseconds, from sector start or read enable, then a pulse count and the sync byte
`define FSTS_GATE_US 96
`define FSTS_RE_US 480
`define FSTS_ACQ_US 125
`define FSTS_DDI_REL_US 32
`define FSTS_BR_FAST_US 32
`define FSTS_HE_US 736
`define FSTS_SECTOR_FLAG_A_US 780
`define FSTS_BLANK_US 44
`define FSTS_ACQ_PULSE_US 16
`define FSTS_ACQ_PULSES 8
`define FSTS_SYNC_PAT 8'hfb

// write path
`define FSTS_WPULSE_NS 650
`define FSTS_WPULSE_CYC (`FSTS_WPULSE_NS / `FSTS_REF_NS)
`define FSTS_WORD_BITS 8
`define FSTS_DATA_POS 8

`endif

/* inc/fsts_pkg.sv */
// types of the floppy sector timing separator
package fsts_pkg;
    typedef enum logic [2:0] {
        FSTS_PH_GATE,
        FSTS_PH_WAIT,
        FSTS_PH_READ,
        FSTS_PH_HUNT,
        FSTS_PH_SECTOR_FLAG_A
    } fsts_phase_type;
endpackage

/* src/fsts_tick_div.sv */
// one divider stage: counts input ticks, gives a wrap tick and a square wave
`timescale 1ns/1ps
module fsts_tick_div #(
    parameter int unsigned DIV = 16,
    parameter int unsigned W = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    output logic tick_o,
    output logic sq_o,
    output logic [W-1:0] cnt_o
);
    import fsts_pkg::*;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    localparam logic [W-1:0] HALF = W'(DIV / 2);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic sq_q;
    wire wrap = tick_i && (cnt_q == LAST);

    assign cnt_d = wrap ? '0 : (tick_i ? cnt_q + 1'b1 : cnt_q);
    assign tick_o = wrap;
    assign sq_o = sq_q;
    assign cnt_o = cnt_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            sq_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            // high in the first half so the rising edge marks the wrap
            sq_q <= (cnt_d < HALF);
        end
    end
endmodule

/* src/fsts_top.sv */
// sector timing, read sequencer and write pulse logic of a floppy controller
// Summary of operation
// - local clock is a 500 ns square wave driving the divider chain.
// - divider gives 8 us, 128 us and 2 ms square-wave taps.
// - a further 32 ms tap marks the sector rate.
// - slow chain gives 500 ms wave and an 8 s (16 x 500 ms) motor auto-off wave.
// - while writing, word counters go low 96 us once per sector.
// - all-ones single density write gives 600-700 ns pulses every 4 us.
// - sector start gate is high 96 us at sector start, then low.
// - read enable rises 480 us after the sector start gate.
// - phase acquisition rises with read enable, lasts 100-150 us.
// - twice bit rate clock low, then 4 us wave for 32 us, then 2 us.
// - double-density flag rises 512 us in, 32 us after read enable.
// - sync hunt enable rises 736 us after sector start.
// - data window toggles as 4 us square wave after read enable.
// - zero data gives only 8 narrow separated pulses during acquisition.
// - zero separated data keeps read shifter and sector_flag_a flag low.
// - on completed hunt sector_flag_a rises at 780 us, with 38-50 us blank pulse.
`timescale 1ns/1ps
`include "fsts_map.svh"
module fsts_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic read_data_i,
    input wire logic write_active_i,
    input wire logic [7:0] write_byte_i,
    output logic local_clock_n_o,
    output logic divider_tap_8us_o,
    output logic divider_tap_128us_o,
    output logic divider_tap_2ms_o,
    output logic divider_tap_sector_o,
    output logic slow_tap_500ms_o,
    output logic auto_off_tap_o,
    output logic write_shifter_load_n_o,
    output logic write_sector_count_a_o,
    output logic write_sector_count_b_o,
    output logic write_pulse_o,
    output logic sector_gate_o,
    output logic read_enable_o,
    output logic acquire_o,
    output logic twice_bit_rate_clk_o,
    output logic double_density_flag_o,
    output logic sync_hunt_enable_o,
    output logic data_window_o,
    output logic separated_bits_o,
    output logic [7:0] read_shifter_bits_o,
    output logic sector_flag_a_o,
    output logic sync_blank_o
);
    import fsts_pkg::*;

    localparam int unsigned TPU = `FSTS_TICK_PER_US;
    localparam logic [15:0] GATE_T = 16'(`FSTS_GATE_US * TPU);
    localparam logic [15:0] RE_T = 16'(`FSTS_RE_US * TPU);
    localparam logic [15:0] ACQ_T = 16'(`FSTS_ACQ_US * TPU);
    localparam logic [15:0] DDI_T = 16'((`FSTS_RE_US + `FSTS_DDI_REL_US) * TPU);
    localparam logic [15:0] FAST_T = 16'(`FSTS_BR_FAST_US * TPU);
    localparam logic [15:0] HE_T = 16'(`FSTS_HE_US * TPU);
    localparam logic [15:0] SECTOR_FLAG_A_T = 16'(`FSTS_SECTOR_FLAG_A_US * TPU);
    localparam logic [7:0] BLANK_T = 8'(`FSTS_BLANK_US * TPU);
    localparam logic [15:0] APULSE_T = 16'(`FSTS_ACQ_PULSE_US * TPU);
    localparam logic [15:0] APULSE_END = 16'(`FSTS_ACQ_PULSE_US * TPU * `FSTS_ACQ_PULSES);
    localparam logic [4:0] WPULSE_C = 5'(`FSTS_WPULSE_CYC);
    localparam logic [3:0] DATA_POS = 4'(`FSTS_DATA_POS);
    localparam logic [2:0] WORD_LAST = 3'(`FSTS_WORD_BITS - 1);
    localparam logic [7:0] SYNC_PAT = `FSTS_SYNC_PAT;

    // reset release and read data synchronisers
    logic rst_meta_q;
    logic rst_n;
    logic rd_meta_q;
    logic rd_sync_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_meta_q <= 1'b0;
            rd_sync_q <= 1'b0;
        end else begin
            rd_meta_q <= read_data_i;
            rd_sync_q <= rd_meta_q;
        end
    end

    // divider chain
    logic t500;
    logic t8;
    logic t128;
    logic t2m;
    logic t32m;
    logic t500m;
    logic local_clock_n;
    logic [3:0] cell_pos;

    fsts_tick_div #(.DIV(`FSTS_LOCAL_CLOCK_N_CYC), .W(5)) u_local_clock_n (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .tick_i(1'b1),
        .tick_o(t500), .sq_o(local_clock_n), .cnt_o());
    fsts_tick_div #(.DIV(`FSTS_TAP8_DIV), .W(4)) u_tap8 (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .tick_i(t500),
        .tick_o(t8), .sq_o(divider_tap_8us_o), .cnt_o(cell_pos));
    fsts_tick_div #(.DIV(`FSTS_CHAIN_DIV), .W(4)) u_tap128 (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .tick_i(t8),
        .tick_o(t128), .sq_o(divider_tap_128us_o), .cnt_o());
    fsts_tick_div #(.DIV(`FSTS_CHAIN_DIV), .W(4)) u_tap2m (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .tick_i(t128),
        .tick_o(t2m), .sq_o(divider_tap_2ms_o), .cnt_o());
    fsts_tick_div #(.DIV(`FSTS_CHAIN_DIV), .W(4)) u_sector (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .tick_i(t2m),
        .tick_o(t32m), .sq_o(divider_tap_sector_o), .cnt_o());
    fsts_tick_div #(.DIV(`FSTS_SLOW_DIV), .W(8)) u_slow (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .tick_i(t2m),
        .tick_o(t500m), .sq_o(slow_tap_500ms_o), .cnt_o());
    fsts_tick_div #(.DIV(`FSTS_AUTO_OFF_DIV), .W(5)) u_auto_off (
        .clk_i(ref_clk_i), .rst_n_i(rst_n), .tick_i(t500m),
        .tick_o(), .sq_o(auto_off_tap_o), .cnt_o());

    assign local_clock_n_o = ~local_clock_n;

    // sector sequencer, offsets counted in local clock ticks from sector start
    fsts_phase_type phase_q;
    fsts_phase_type phase_d;
    logic [15:0] seq_cnt_q;
    logic [15:0] seq_cnt_d;
    logic sync_found_q;
    wire sec_start = t32m;
    wire [15:0] rel = seq_cnt_q - RE_T;
    wire in_re = seq_cnt_q >= RE_T;
    wire in_acq = in_re && (rel < ACQ_T);
    wire br_fast = rel < FAST_T;
    wire br_level = in_re && (br_fast ? ~rel[2] : ~rel[1]);
    wire apulse = in_acq && t500 && (rel < APULSE_END) && (rel % APULSE_T == 16'h0000);

    assign seq_cnt_d = sec_start ? 16'h0000 :
                       (t500 && seq_cnt_q != 16'hffff) ? seq_cnt_q + 16'h0001 : seq_cnt_q;

    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            FSTS_PH_GATE: begin
                if (seq_cnt_q >= GATE_T) begin
                    phase_d = FSTS_PH_WAIT;
                end
            end
            FSTS_PH_WAIT: begin
                if (in_re) begin
                    phase_d = FSTS_PH_READ;
                end
            end
            FSTS_PH_READ: begin
                if (seq_cnt_q >= HE_T) begin
                    phase_d = FSTS_PH_HUNT;
                end
            end
            FSTS_PH_HUNT: begin
                if (sync_found_q && seq_cnt_q >= SECTOR_FLAG_A_T) begin
                    phase_d = FSTS_PH_SECTOR_FLAG_A;
                end
            end
            FSTS_PH_SECTOR_FLAG_A: begin
                phase_d = FSTS_PH_SECTOR_FLAG_A;
            end
            default: begin
                phase_d = FSTS_PH_GATE;
            end
        endcase
        if (sec_start) begin
            phase_d = FSTS_PH_GATE;
        end
    end

    // cleared by the synchronised block reset rst_n back to the gate phase with the count at zero
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seq_cnt_q <= 16'h0000;
            phase_q <= FSTS_PH_GATE;
        end else begin
            seq_cnt_q <= seq_cnt_d;
            phase_q <= phase_d;
        end
    end

    // read side: window, separated bits, shifter and sync hunt
    logic dwin_q;
    logic bit_seen_q;
    logic [7:0] rshift_q;
    logic [7:0] blank_cnt_q;
    logic sector_flag_a_q;
    wire cell_end = in_re && t500 && (rel[2:0] == 3'h7);
    wire raw_bit = rd_sync_q && dwin_q && in_re && !in_acq;
    wire hunt_hit = (phase_q == FSTS_PH_HUNT) && (rshift_q == SYNC_PAT);
    wire sector_flag_a_d = (phase_q == FSTS_PH_SECTOR_FLAG_A) || (phase_q == FSTS_PH_HUNT && phase_d == FSTS_PH_SECTOR_FLAG_A);

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dwin_q <= 1'b0;
            bit_seen_q <= 1'b0;
            rshift_q <= 8'h00;
        end else begin
            dwin_q <= in_re ? ~rel[2] : dwin_q;
            bit_seen_q <= cell_end ? 1'b0 : (bit_seen_q | raw_bit);
            if (sec_start) begin
                rshift_q <= 8'h00;
            end else if (cell_end) begin
                rshift_q <= {rshift_q[6:0], bit_seen_q | raw_bit};
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_found_q <= 1'b0;
            sector_flag_a_q <= 1'b0;
            blank_cnt_q <= 8'h00;
        end else begin
            if (sec_start) begin
                sync_found_q <= 1'b0;
            end else if (hunt_hit) begin
                sync_found_q <= 1'b1;
            end
            sector_flag_a_q <= sector_flag_a_d;
            if (sector_flag_a_d && !sector_flag_a_q) begin
                blank_cnt_q <= BLANK_T;
            end else if (t500 && blank_cnt_q != 8'h00) begin
                blank_cnt_q <= blank_cnt_q - 8'h01;
            end
        end
    end

    // registered sequencer outputs
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sector_gate_o <= 1'b0;
            read_enable_o <= 1'b0;
            acquire_o <= 1'b0;
            twice_bit_rate_clk_o <= 1'b0;
            double_density_flag_o <= 1'b0;
            sync_hunt_enable_o <= 1'b0;
            separated_bits_o <= 1'b0;
        end else begin
            sector_gate_o <= seq_cnt_q < GATE_T;
            read_enable_o <= in_re;
            acquire_o <= in_acq;
            twice_bit_rate_clk_o <= br_level;
            double_density_flag_o <= seq_cnt_q >= DDI_T;
            sync_hunt_enable_o <= seq_cnt_q >= HE_T;
            separated_bits_o <= apulse | raw_bit;
        end
    end

    assign data_window_o = dwin_q;
    assign read_shifter_bits_o = rshift_q;
    assign sector_flag_a_o = sector_flag_a_q;
    assign sync_blank_o = blank_cnt_q != 8'h00;

    // write side: word counter, shifter load, clock and data pulses
    logic [2:0] word_q;
    logic [7:0] wshift_q;
    logic [4:0] wpulse_q;
    logic wload_n_q;
    logic wsc_q;
    wire word_end = t8 && (word_q == WORD_LAST);
    wire clk_slot = t500 && (cell_pos == 4'h0);
    wire data_slot = t500 && (cell_pos == DATA_POS) && wshift_q[7];
    wire fire = write_active_i && (clk_slot || data_slot);

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= 3'h0;
            wshift_q <= 8'h00;
            wpulse_q <= 5'h00;
            wload_n_q <= 1'b1;
            wsc_q <= 1'b1;
        end else begin
            word_q <= t8 ? word_q + 3'h1 : word_q;
            if (word_end) begin
                wshift_q <= write_byte_i;
            end else if (t8) begin
                wshift_q <= {wshift_q[6:0], 1'b0};
            end
            if (t8) begin
                wload_n_q <= (word_q + 3'h1) != WORD_LAST;
            end
            if (fire) begin
                wpulse_q <= WPULSE_C;
            end else if (wpulse_q != 5'h00) begin
                wpulse_q <= wpulse_q - 5'h01;
            end
            wsc_q <= !(write_active_i && seq_cnt_q < GATE_T);
        end
    end

    assign write_shifter_load_n_o = wload_n_q;
    assign write_pulse_o = wpulse_q != 5'h00;
    assign write_sector_count_a_o = wsc_q;
    assign write_sector_count_b_o = wsc_q;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    property p_local_clock_n;
        $rose(local_clock_n_o) |-> ##10 $fell(local_clock_n_o);
    endproperty
    a_local_clock_n: assert property (p_local_clock_n) else $error("local clock half period wrong");

    property p_tap8;
        $rose(divider_tap_8us_o) |-> ##160 $fell(divider_tap_8us_o);
    endproperty
    a_tap8: assert property (p_tap8) else $error("8us tap half period wrong");

    property p_gate;
        $fell(sector_gate_o) |-> seq_cnt_q == GATE_T;
    endproperty
    a_gate: assert property (p_gate) else $error("sector gate width wrong");

    property p_re;
        $rose(read_enable_o) |-> seq_cnt_q == RE_T && acquire_o;
    endproperty
    a_re: assert property (p_re) else $error("read enable offset wrong");

    property p_acq;
        $fell(acquire_o) |-> read_enable_o && seq_cnt_q == RE_T + ACQ_T;
    endproperty
    a_acq: assert property (p_acq) else $error("acquire length wrong");

    property p_br;
        !read_enable_o |-> !twice_bit_rate_clk_o;
    endproperty
    a_br: assert property (p_br) else $error("twice bit rate clock runs early");

    property p_ddi;
        $rose(double_density_flag_o) |-> seq_cnt_q == DDI_T && read_enable_o;
    endproperty
    a_ddi: assert property (p_ddi) else $error("density flag offset wrong");

    property p_he;
        $rose(sync_hunt_enable_o) |-> seq_cnt_q == HE_T;
    endproperty
    a_he: assert property (p_he) else $error("hunt enable offset wrong");

    property p_sector_flag_a;
        $rose(sector_flag_a_o) |-> seq_cnt_q >= SECTOR_FLAG_A_T && sync_blank_o;
    endproperty
    a_sector_flag_a: assert property (p_sector_flag_a) else $error("sector_flag_a flag or blank wrong");

    property p_wpulse;
        $rose(write_pulse_o) |-> ##25 write_pulse_o ##1 !write_pulse_o;
    endproperty
    a_wpulse: assert property (p_wpulse) else $error("write pulse width wrong");

    c_sector_flag_a: cover property ($rose(sector_flag_a_o));
    c_wpulse: cover property ($rose(write_pulse_o));
    c_gate: cover property ($fell(sector_gate_o));
    c_acq: cover property ($rose(separated_bits_o) && acquire_o);
endmodule

/* tb/fsts_drive_model.sv */
// drive model: zero bits on the read line, or a repeating byte once streaming
`timescale 1ns/1ps
module fsts_drive_model #(
    parameter logic [7:0] PATTERN = 8'hfb,
    parameter int CELL = 160
) (
    input wire logic clk_i,
    input wire logic stream_i,
    output logic read_data_o
);
    int cyc = 0;

    // each bit is a pulse in the first half of its 4 us cell, msb first;
    // the idle second half keeps a one from spilling into the next window
    always @(posedge clk_i) begin
        if (!stream_i) begin
            cyc <= 0;
            read_data_o <= #1 1'b0;
        end else begin
            cyc <= cyc + 1;
            read_data_o <= #1 PATTERN[7 - ((cyc / CELL) % 8)] && (cyc % CELL < CELL / 2);
        end
    end
endmodule

/* tb/test_floppy_sector_timing_separator.sv */
// self-checking bench for the floppy sector timing separator
`timescale 1ns/1ps
module test_floppy_sector_timing_separator;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic read_data;
    logic write_active = 1'b0;
    logic [7:0] write_byte = 8'hff;
    logic stream = 1'b0;
    logic local_clock_n_n, tap8, tap128, tap2m, tap_sec, slow, auto_off, load_n;
    logic wsc_a, wsc_b, wpulse, gate, re, acq, tbr, double_density_flag, he, dw, sep, sector_flag_a, blank;
    logic [7:0] rsb;
    logic [4:0] taps;
    int failures = 0;
    int checked = 0;

    assign taps = {wpulse, ~load_n, tap128, tap8, ~local_clock_n_n};

    always #12.5 ref_clk = ~ref_clk;

    fsts_drive_model u_fsts_drive_model (.clk_i(ref_clk), .stream_i(stream),
        .read_data_o(read_data));

    fsts_top u_fsts_top (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .read_data_i(read_data),
        .write_active_i(write_active), .write_byte_i(write_byte),
        .local_clock_n_o(local_clock_n_n), .divider_tap_8us_o(tap8), .divider_tap_128us_o(tap128),
        .divider_tap_2ms_o(tap2m), .divider_tap_sector_o(tap_sec), .slow_tap_500ms_o(slow),
        .auto_off_tap_o(auto_off), .write_shifter_load_n_o(load_n),
        .write_sector_count_a_o(wsc_a), .write_sector_count_b_o(wsc_b),
        .write_pulse_o(wpulse), .sector_gate_o(gate), .read_enable_o(re), .acquire_o(acq),
        .twice_bit_rate_clk_o(tbr), .double_density_flag_o(double_density_flag), .sync_hunt_enable_o(he),
        .data_window_o(dw), .separated_bits_o(sep), .read_shifter_bits_o(rsb),
        .sector_flag_a_o(sector_flag_a), .sync_blank_o(blank));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // rounds a cycle count to 500 ns ticks
    function automatic int tk(input int c);
        return (c + 10) / 20;
    endfunction

    // high time and period of one periodic output, in reference cycles
    task automatic period(input int i, input int hi_e, input int per_e);
        int hi;
        int per;
        hi = 0;
        while (taps[i] !== 1'b0) @(posedge ref_clk);
        while (taps[i] !== 1'b1) @(posedge ref_clk);
        while (taps[i] === 1'b1) begin
            @(posedge ref_clk);
            hi++;
        end
        per = hi;
        while (taps[i] !== 1'b1) begin
            @(posedge ref_clk);
            per++;
        end
        check(hi, hi_e);
        check(per, per_e);
    endtask

    task automatic t_divider();
        period(0, 10, 20);
        period(1, 160, 320);
        period(2, 2560, 5120);
        period(3, 320, 2560);
        period(4, 26, 160);
    endtask

    // first sector after reset: zero data until the hunt, then the sync byte streamed
    task automatic t_sector();
        int gf = -1, wr = -1, ra = -1, ae = -1, da = -1, ha = -1, ba = -1, bf = -1, tf = -1;
        int tl = -1, pf = -1, ps = -1, dl = -1, dp = -1;
        int pulses = 0, stray = 0, tbr_bad = 0, rs_bad = 0, ab = 0, bb = 0, n;
        logic sq = 1'b0, tq = 1'b0, dq = 1'b0;
        while (gate !== 1'b0) @(posedge ref_clk);
        while (gate !== 1'b1) @(posedge ref_clk);
        for (n = 1; n < 41000; n++) begin
            @(posedge ref_clk);
            if (gate === 1'b0 && gf < 0) gf = n;
            if (tap2m === 1'b0 && tf < 0) tf = n;
            if (wsc_a === 1'b1 && wr < 0) wr = n;
            if (wsc_a !== wsc_b) wr = -9;
            if (re === 1'b1 && ra < 0) begin
                ra = n;
                ab = (acq === 1'b1);
            end
            if (ra < 0 && tbr !== 1'b0) tbr_bad++;
            if (ra >= 0 && acq === 1'b0 && ae < 0) ae = n;
            if (double_density_flag === 1'b1 && da < 0) da = n;
            if (he === 1'b1 && ha < 0) begin
                ha = n;
                stream <= #1 1'b1;
            end
            if (sep === 1'b1 && !sq && acq === 1'b1) pulses++;
            if (sep === 1'b1 && !sq && acq !== 1'b1 && ha < 0) stray++;
            if (ha < 0 && (rsb !== 8'h00 || sector_flag_a !== 1'b0)) rs_bad++;
            if (tbr === 1'b1 && !tq) begin
                if (ra >= 0 && tl > ra && n < ra + 1280 && pf < 0) pf = n - tl;
                if (ra >= 0 && n > ra + 2000) ps = n - tl;
                tl = n;
            end
            if (dw === 1'b1 && !dq) begin
                if (ra >= 0 && dl > ra) dp = n - dl;
                dl = n;
            end
            if (sector_flag_a === 1'b1 && ba < 0) begin
                ba = n;
                bb = (blank === 1'b1);
            end
            if (ba >= 0 && blank === 1'b0 && bf < 0) bf = n;
            sq = sep;
            tq = tbr;
            dq = dw;
        end
        stream <= #1 1'b0;
        check(tk(gf), 192);
        check(tk(wr), 192);
        check(tk(ra), 960);
        check(ab, 1);
        check(tk(ae - ra) >= 200 && tk(ae - ra) <= 300, 1);
        check(tbr_bad, 0);
        check(pf, 160);
        check(ps, 80);
        check(tk(da), 1024);
        check(tk(da - ra), 64);
        check(tk(ha), 1472);
        check(dp, 160);
        check(pulses, 8);
        check(stray, 0);
        check(rs_bad, 0);
        check(tk(ba), 1560);
        check(bb, 1);
        check(tk(bf - ba) >= 76 && tk(bf - ba) <= 100, 1);
        check(tk(tf), 2048);
        // the slow taps are still in their high first half this early
        check(tap_sec, 1'b1);
        check({slow, auto_off}, 2'b11);
    endtask

    // a mid-run reset restarts the sector sequence from its gate
    task automatic t_restart();
        int n = 0;
        int ra = -1;
        @(posedge ref_clk);
        rst_b <= #1 1'b0;
        repeat (4) @(posedge ref_clk);
        check({gate, re, acq, sector_flag_a}, 4'h0);
        rst_b <= #1 1'b1;
        while (gate !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        check(n, 4);
        for (n = 1; n < 20000 && ra < 0; n++) begin
            @(posedge ref_clk);
            if (re === 1'b1) ra = n;
        end
        check(tk(ra), 960);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= #1 1'b1;
        write_active <= #1 1'b1;
        t_sector();
        t_divider();
        t_restart();
        summarize();
    end

    // watchdog with margin over the roughly 75000 cycles the tests take
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        summarize();
    end
endmodule
